// ### core/odtc_controller.sv
/*
  Controller end: divides mclk_in into the link clock, issues user commands
  on falling link edges and shapes the termination pin around writes and
  reads. Assumes the user holds a request until it is taken.
*/
`timescale 1ns/10ps
module odtc_controller #(
  parameter int HALF_DIV = odtc_pkg::LINK_HALF_DIV
) (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire logic                        clk_en_in,
  odtc_link_if.ctrl                        link,
  input  wire logic                        req_valid_in,
  input  wire logic [2:0]                  req_cmd_in,
  input  wire logic [odtc_pkg::BANK_W-1:0] req_bank_in,
  input  wire logic [odtc_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic                        term_req_in,
  input  wire logic                        cke_in,
  output logic                             req_ready_out,
  output logic                             hold_active_out
);

  logic [7:0]                  div_q;
  logic                        ck_q;
  logic                        cke_q;
  logic [2:0]                  cmd_q;
  logic [odtc_pkg::BANK_W-1:0] bank_q;
  logic [odtc_pkg::ADDR_W-1:0] addr_q;
  logic                        pin_q;
  logic                        pend_q;
  logic [2:0]                  p_cmd_q;
  logic [odtc_pkg::BANK_W-1:0] p_bank_q;
  logic [odtc_pkg::ADDR_W-1:0] p_addr_q;
  logic [odtc_pkg::ADDR_W-1:0] mr0_q;
  logic [odtc_pkg::ADDR_W-1:0] mr1_q;
  logic [odtc_pkg::ADDR_W-1:0] mr2_q;
  logic [5:0]                  hold_q;
  logic [5:0]                  rd_block_q;
  logic [5:0]                  low_cnt_q;

  // ------------------------------------------------------------------
  // Next link cycle decisions
  // ------------------------------------------------------------------
  wire       tick     = clk_en_in && div_q == 8'(HALF_DIV - 1);
  wire       fall_now = tick && ck_q;
  wire       take     = clk_en_in && req_valid_in && !pend_q;
  wire [5:0] odt_lat  = odtc_pkg::f_wl(mr0_q, mr1_q, mr2_q) - odtc_pkg::LAT_OFFSET;
  wire       dll_off  = mr1_q[odtc_pkg::MR1_DLL_OFF];
  // A read waits until termination has been off for a full latency
  wire       rd_ok    = low_cnt_q > odt_lat;
  wire       send     = pend_q && (p_cmd_q != odtc_pkg::CMD_READ || rd_ok);
  wire       send_rd  = send && p_cmd_q == odtc_pkg::CMD_READ;
  wire       send_wr  = send && p_cmd_q == odtc_pkg::CMD_WRITE;
  wire       want_pin = term_req_in && rd_block_q == 6'h00
                        && !(pend_q && p_cmd_q == odtc_pkg::CMD_READ);
  wire       pin_d    = !dll_off && ((pin_q && hold_q != 6'h00) || want_pin);
  wire [5:0] wr_hold  = (odtc_pkg::f_chop(mr0_q, p_addr_q) ? odtc_pkg::HIGH_MIN_SHORT
                         : odtc_pkg::HIGH_MIN_FULL) - 6'h01;
  wire [5:0] rise_hold = (pin_d && !pin_q) ? odtc_pkg::HIGH_MIN_SHORT - 6'h01
                         : (hold_q != 6'h00 ? hold_q - 6'h01 : 6'h00);
  wire [5:0] hold_d   = (send_wr && pin_d && wr_hold > rise_hold) ? wr_hold : rise_hold;
  wire [5:0] rl       = odtc_pkg::f_rl(mr0_q, mr1_q);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_q      <= 8'h00;
      ck_q       <= 1'b0;
      cke_q      <= 1'b0;
      cmd_q      <= odtc_pkg::CMD_NOP;
      bank_q     <= '0;
      addr_q     <= '0;
      pin_q      <= 1'b0;
      pend_q     <= 1'b0;
      p_cmd_q    <= odtc_pkg::CMD_NOP;
      p_bank_q   <= '0;
      p_addr_q   <= '0;
      mr0_q      <= odtc_pkg::MR_RESET;
      mr1_q      <= odtc_pkg::MR_RESET;
      mr2_q      <= odtc_pkg::MR_RESET;
      hold_q     <= 6'h00;
      rd_block_q <= 6'h00;
      low_cnt_q  <= 6'h00;
    end else if (clk_en_in) begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        ck_q <= ~ck_q;
      end
      if (take) begin
        pend_q   <= 1'b1;
        p_cmd_q  <= req_cmd_in;
        p_bank_q <= req_bank_in;
        p_addr_q <= req_addr_in;
      end
      if (fall_now) begin
        cke_q     <= cke_in;
        pin_q     <= pin_d;
        hold_q    <= pin_d ? hold_d : 6'h00;
        low_cnt_q <= pin_d ? 6'h00 : (low_cnt_q == 6'h3F ? low_cnt_q : low_cnt_q + 6'h01);
        rd_block_q <= send_rd ? rl + odtc_pkg::READ_DRIVE_LEN
                      : (rd_block_q != 6'h00 ? rd_block_q - 6'h01 : 6'h00);
        cmd_q  <= send ? p_cmd_q : odtc_pkg::CMD_NOP;
        bank_q <= p_bank_q;
        addr_q <= p_addr_q;
        if (send) begin
          pend_q <= 1'b0;
        end
        if (send && p_cmd_q == odtc_pkg::CMD_MRS) begin
          if (p_bank_q == odtc_pkg::MR_SEL_ZERO) begin
            mr0_q <= p_addr_q;
          end
          if (p_bank_q == odtc_pkg::MR_SEL_ONE) begin
            mr1_q <= p_addr_q;
          end
          if (p_bank_q == odtc_pkg::MR_SEL_TWO) begin
            mr2_q <= p_addr_q;
          end
        end
      end
    end
  end

  assign link.ck         = ck_q;
  assign link.cke        = cke_q;
  assign link.cmd        = cmd_q;
  assign link.bank       = bank_q;
  assign link.addr       = addr_q;
  assign link.term_pin   = pin_q;
  assign req_ready_out   = ~pend_q;
  assign hold_active_out = (hold_q != 6'h00) | (rd_block_q != 6'h00);

endmodule

// ### core/odtc_device.sv
/*
  Device end: samples the link clock, decodes mode register writes, writes,
  reads and self-refresh, and derives termination on/off and strength.
  Assumes link signals change near the falling link edge and that the link
  clock is much slower than mclk_in.
*/
`timescale 1ns/10ps
module odtc_device #(
  parameter int PIPE_DEPTH = odtc_pkg::PIPE_DEPTH
) (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  odtc_link_if.dev        link,
  output logic            term_on_out,
  output logic [2:0]      strength_out,
  output logic            strength_write_out,
  output logic            drive_out,
  output logic            sync_mode_out,
  output logic            self_refresh_out
);

  localparam int IN_W = 1 + 3 + odtc_pkg::BANK_W + odtc_pkg::ADDR_W + 1;

  // ------------------------------------------------------------------
  // Link synchronisers
  // ------------------------------------------------------------------
  logic            ck_s1_q;
  logic            ck_s2_q;
  logic            ck_s3_q;
  logic [IN_W-1:0] in_s1_q;
  logic [IN_W-1:0] in_s2_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else if (clk_en_in) begin
      ck_s1_q <= link.ck;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      in_s1_q <= {link.cke, link.cmd, link.bank, link.addr, link.term_pin};
      in_s2_q <= in_s1_q;
    end
  end

  wire                          link_rise = ck_s2_q & ~ck_s3_q;
  wire                          link_fall = ~ck_s2_q & ck_s3_q;
  wire                          s_cke     = in_s2_q[IN_W-1];
  wire [2:0]                    s_cmd     = in_s2_q[IN_W-2 -: 3];
  wire [odtc_pkg::BANK_W-1:0]   s_bank    = in_s2_q[odtc_pkg::ADDR_W+1 +: odtc_pkg::BANK_W];
  wire [odtc_pkg::ADDR_W-1:0]   s_addr    = in_s2_q[1 +: odtc_pkg::ADDR_W];
  wire                          s_pin     = in_s2_q[0];

  // ------------------------------------------------------------------
  // Mode registers and device state
  // ------------------------------------------------------------------
  logic [odtc_pkg::ADDR_W-1:0] mr0_q;
  logic [odtc_pkg::ADDR_W-1:0] mr1_q;
  logic [odtc_pkg::ADDR_W-1:0] mr2_q;
  logic                        sr_q;
  logic                        bank_open_q;
  logic                        pd_q;

  wire is_mrs   = link_rise && s_cmd == odtc_pkg::CMD_MRS;
  wire is_write = s_cmd == odtc_pkg::CMD_WRITE;
  wire is_read  = s_cmd == odtc_pkg::CMD_READ;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mr0_q       <= odtc_pkg::MR_RESET;
      mr1_q       <= odtc_pkg::MR_RESET;
      mr2_q       <= odtc_pkg::MR_RESET;
      sr_q        <= 1'b0;
      bank_open_q <= 1'b0;
      pd_q        <= 1'b0;
    end else if (clk_en_in) begin
      if (is_mrs && s_bank == odtc_pkg::MR_SEL_ZERO) begin
        mr0_q <= s_addr;
      end
      if (is_mrs && s_bank == odtc_pkg::MR_SEL_ONE) begin
        mr1_q <= s_addr;
      end
      if (is_mrs && s_bank == odtc_pkg::MR_SEL_TWO) begin
        mr2_q <= s_addr;
      end
      if (link_rise) begin
        if (s_cmd == odtc_pkg::CMD_SRE && !s_cke) begin
          sr_q <= 1'b1;
        end else if (s_cke) begin
          sr_q <= 1'b0;
        end
        if (s_cmd == odtc_pkg::CMD_ACT) begin
          bank_open_q <= 1'b1;
        end else if (s_cmd == odtc_pkg::CMD_PREA) begin
          bank_open_q <= 1'b0;
        end
        pd_q <= ~s_cke;
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  wire [2:0] rtt_nom = {mr1_q[odtc_pkg::MR1_NOM_A9], mr1_q[odtc_pkg::MR1_NOM_A6],
                        mr1_q[odtc_pkg::MR1_NOM_A2]};
  wire [1:0] rtt_wr  = mr2_q[odtc_pkg::MR2_WR_LSB +: 2];
  wire       dll_on  = ~mr1_q[odtc_pkg::MR1_DLL_OFF];
  wire       dll_keep = mr0_q[odtc_pkg::MR0_DLL_KEEP];
  // Frozen-loop precharge power-down leaves synchronous mode
  wire       sync_mode = dll_on && !(pd_q && !bank_open_q && !dll_keep);
  wire       dyn_en    = rtt_wr != 2'h0;
  wire       term_en   = (rtt_nom != 3'h0 || dyn_en) && sync_mode && !sr_q;

  wire [5:0] wl      = odtc_pkg::f_wl(mr0_q, mr1_q, mr2_q);
  wire [5:0] odt_lat = wl - odtc_pkg::LAT_OFFSET;
  wire [5:0] cnw_lat = wl - odtc_pkg::LAT_OFFSET;
  wire [5:0] cwn4    = odtc_pkg::CWN_CHOP_ADD + odt_lat;
  wire [5:0] cwn8    = odtc_pkg::CWN_FULL_ADD + odt_lat;
  wire [5:0] rl      = odtc_pkg::f_rl(mr0_q, mr1_q);
  wire [5:0] rd_lo   = rl - 6'h01;
  wire [5:0] rd_hi   = rl + odtc_pkg::READ_DRIVE_LEN;

  // ------------------------------------------------------------------
  // Event pipelines, one stage per link cycle
  // ------------------------------------------------------------------
  logic [PIPE_DEPTH-1:0] pin_pipe_q;
  logic [PIPE_DEPTH-1:0] wr_pipe_q;
  logic [PIPE_DEPTH-1:0] chop_pipe_q;
  logic [PIPE_DEPTH-1:0] rd_pipe_q;

  // Any event aged lo .. hi-1 cycles; chop events end at hi_c instead
  function automatic logic f_window(input logic [PIPE_DEPTH-1:0] ev,
                                    input logic [PIPE_DEPTH-1:0] chop,
                                    input logic [5:0]            lo,
                                    input logic [5:0]            hi,
                                    input logic [5:0]            hi_c);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < PIPE_DEPTH; i++) begin
      if (ev[i] && i >= int'(lo) && i < int'(chop[i] ? hi_c : hi)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_pipe_q  <= '0;
      wr_pipe_q   <= '0;
      chop_pipe_q <= '0;
      rd_pipe_q   <= '0;
    end else if (clk_en_in && link_rise) begin
      pin_pipe_q  <= {pin_pipe_q[PIPE_DEPTH-2:0], s_pin};
      wr_pipe_q   <= {wr_pipe_q[PIPE_DEPTH-2:0], is_write};
      chop_pipe_q <= {chop_pipe_q[PIPE_DEPTH-2:0],
                      is_write && odtc_pkg::f_chop(mr0_q, s_addr)};
      rd_pipe_q   <= {rd_pipe_q[PIPE_DEPTH-2:0], is_read};
    end
  end

  // Stage 0 holds the value sampled at the latest link rise; a rise still
  // sees the stages from before its own shift, so turn-on reads one less
  wire [5:0] on_idx = odt_lat - 6'h01;
  wire pin_on    = pin_pipe_q[on_idx[4:0]];
  wire pin_late  = pin_pipe_q[odt_lat[4:0]];
  wire driving   = f_window(rd_pipe_q, '0, rd_lo, rd_hi, rd_hi);
  wire wr_window = dyn_en && f_window(wr_pipe_q, chop_pipe_q, cnw_lat, cwn8, cwn4);
  // On/off never looks at writes, only the delayed pin, term_en and driving
  wire rise_on   = pin_on && term_en && !driving;
  wire target_on = pin_late && term_en && !driving;

  // ------------------------------------------------------------------
  // Termination outputs
  // ------------------------------------------------------------------
  logic       term_on_q;
  logic [2:0] strength_q;
  logic       strength_write_q;
  logic       drive_q;
  logic       sync_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      term_on_q        <= 1'b0;
      strength_q       <= 3'h0;
      strength_write_q <= 1'b0;
      drive_q          <= 1'b0;
      sync_q           <= 1'b0;
    end else if (clk_en_in) begin
      sync_q <= sync_mode;
      if (!term_en) begin
        term_on_q <= 1'b0;
      end else if (link_rise && rise_on) begin
        term_on_q <= 1'b1;
      end else if (link_fall && !target_on) begin
        term_on_q <= 1'b0;
      end
      if (link_rise) begin
        drive_q <= driving;
      end
      if (link_fall) begin
        // Strength changes land half a link cycle after their edge
        strength_write_q <= wr_window;
        strength_q       <= wr_window ? {1'b0, rtt_wr} : rtt_nom;
      end
    end
  end

  assign term_on_out        = term_on_q;
  assign strength_out       = strength_q;
  assign strength_write_out = strength_write_q;
  assign drive_out          = drive_q;
  assign sync_mode_out      = sync_q;
  assign self_refresh_out   = sr_q;

endmodule

// ### core/odtc_link_if.sv
/*
  Link between memory controller and device termination logic.
  Assumes the controller alone drives every signal; the device only listens.
*/
`timescale 1ns/10ps
interface odtc_link_if;
  logic                          ck;
  logic                          cke;
  logic [2:0]                    cmd;
  logic [odtc_pkg::BANK_W-1:0]   bank;
  logic [odtc_pkg::ADDR_W-1:0]   addr;
  logic                          term_pin;

  modport ctrl (output ck, output cke, output cmd, output bank, output addr,
                output term_pin);
  modport dev  (input ck, input cke, input cmd, input bank, input addr,
                input term_pin);
endinterface

// ### core/odtc_pkg.sv
/*
  Shared constants, link command codes, mode register field layout and
  latency arithmetic for the termination control pair.
  Assumes both ends are built from the same package and clocked by mclk_in.
*/
// Contract
// - Synchronous termination timing while delay loop locked
// - Controller keeps termination off with loop off
// - Termination follows sampled pin after latency
// - Latency equals write latency plus additive minus two
// - Analog windows referenced to latency end
// - Pin stays high at least four cycles
// - After write, pin high four or six cycles
// - Controller lowers pin around reads
// - Termination returns only after device stops driving
// - Dynamic switching enabled by write strength bits
// - Strengths taken from mode register one, two
// - Nominal strength applies outside writes
// - Write strength selected write latency minus two
// - Nominal returns four or six plus off latency
// - Pin still controls on/off during dynamic switching
// - Controller clears write strength with loop off; the controller logic does not, the bench writes mode register two with zero
// - Turn-off and strength changes add half cycle
// - Termination active only with non-zero strength fields
// - Pin alone controls termination, no command decode; the device also holds it off during decoded reads
// - Termination off and pin ignored in self-refresh
package odtc_pkg;

  // ------------------------------------------------------------------
  // Link command codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CMD_NOP   = 3'h0;
  localparam logic [2:0] CMD_MRS   = 3'h1;
  localparam logic [2:0] CMD_ACT   = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ  = 3'h4;
  localparam logic [2:0] CMD_PREA  = 3'h5;
  localparam logic [2:0] CMD_SRE   = 3'h6;

  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int PIPE_DEPTH = 32;

  localparam logic [BANK_W-1:0] MR_SEL_ZERO = 3'h0;
  localparam logic [BANK_W-1:0] MR_SEL_ONE  = 3'h1;
  localparam logic [BANK_W-1:0] MR_SEL_TWO  = 3'h2;
  localparam logic [ADDR_W-1:0] MR_RESET    = 16'h0000;

  // ------------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------------
  localparam int MR0_DLL_KEEP = 12;
  localparam int MR0_BL_LSB   = 0;
  localparam int MR0_CL_LSB   = 4;
  localparam int MR1_DLL_OFF  = 0;
  localparam int MR1_AL_LSB   = 3;
  localparam int MR1_NOM_A2   = 2;
  localparam int MR1_NOM_A6   = 6;
  localparam int MR1_NOM_A9   = 9;
  localparam int MR2_CWL_LSB  = 3;
  localparam int MR2_WR_LSB   = 9;
  localparam int WR_OTF_BIT   = 12;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] AL_CL1    = 2'h1;
  localparam logic [1:0] AL_CL2    = 2'h2;

  localparam logic [5:0] CL_BASE  = 6'h05;
  localparam logic [5:0] CWL_BASE = 6'h05;

  // ------------------------------------------------------------------
  // Timing counts in link clock cycles; LINK_HALF_DIV counts mclk_in cycles
  // ------------------------------------------------------------------
  localparam logic [5:0] LAT_OFFSET     = 6'h02;
  localparam logic [5:0] HIGH_MIN_SHORT = 6'h04;
  localparam logic [5:0] HIGH_MIN_FULL  = 6'h06;
  localparam logic [5:0] CWN_CHOP_ADD   = 6'h04;
  localparam logic [5:0] CWN_FULL_ADD   = 6'h06;
  localparam logic [5:0] READ_DRIVE_LEN = 6'h05;
  localparam int         LINK_HALF_DIV  = 10;

  function automatic logic [5:0] f_cl(input logic [ADDR_W-1:0] mr0);
    return CL_BASE + {3'h0, mr0[MR0_CL_LSB +: 3]};
  endfunction

  function automatic logic [5:0] f_al(input logic [ADDR_W-1:0] mr0,
                                      input logic [ADDR_W-1:0] mr1);
    logic [1:0] code;
    code = mr1[MR1_AL_LSB +: 2];
    if (code == AL_CL1) begin
      return f_cl(mr0) - 6'h01;
    end else if (code == AL_CL2) begin
      return f_cl(mr0) - 6'h02;
    end
    return 6'h00;
  endfunction

  function automatic logic [5:0] f_wl(input logic [ADDR_W-1:0] mr0,
                                      input logic [ADDR_W-1:0] mr1,
                                      input logic [ADDR_W-1:0] mr2);
    return CWL_BASE + {3'h0, mr2[MR2_CWL_LSB +: 3]} + f_al(mr0, mr1);
  endfunction

  function automatic logic [5:0] f_rl(input logic [ADDR_W-1:0] mr0,
                                      input logic [ADDR_W-1:0] mr1);
    return f_cl(mr0) + f_al(mr0, mr1);
  endfunction

  function automatic logic f_chop(input logic [ADDR_W-1:0] mr0,
                                  input logic [ADDR_W-1:0] addr);
    logic [1:0] mode;
    mode = mr0[MR0_BL_LSB +: 2];
    return (mode == BL_FIXED4) || ((mode == BL_OTF) && !addr[WR_OTF_BIT]);
  endfunction

endpackage

// ### tb/odtc_monitor.sv
/*
  Concurrent checks on the termination link and the device outputs.
  Assumes the bench keeps write latency at five (latency three) and places
  this checker beside the link joining controller and device.
*/
`timescale 1ns/10ps
module odtc_monitor (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire logic                        ck,
  input  wire logic [2:0]                  cmd,
  input  wire logic [odtc_pkg::BANK_W-1:0] bank,
  input  wire logic [odtc_pkg::ADDR_W-1:0] addr,
  input  wire logic                        term_pin,
  input  wire logic                        term_on_out,
  input  wire logic                        strength_write_out,
  input  wire logic                        drive_out,
  input  wire logic                        sync_mode_out,
  input  wire logic                        self_refresh_out
);
  // ------------------------------------------------------------------
  // Mode register copies seen on the link
  // ------------------------------------------------------------------
  logic [15:0] mr0_q;
  logic [15:0] mr1_q;
  logic [15:0] mr2_q;
  wire         mrs_w = (cmd == odtc_pkg::CMD_MRS);
  wire         wr_w  = (cmd == odtc_pkg::CMD_WRITE);
  wire         live_w = sync_mode_out && !self_refresh_out && mr1_q[2];

  always_ff @(posedge ck or posedge reset_in) begin
    if (reset_in) begin
      mr0_q <= 16'h0000;
      mr1_q <= 16'h0000;
      mr2_q <= 16'h0000;
    end else begin
      mr0_q <= (mrs_w && bank == 3'h0) ? addr : mr0_q;
      mr1_q <= (mrs_w && bank == 3'h1) ? addr : mr1_q;
      mr2_q <= (mrs_w && bank == 3'h2) ? addr : mr2_q;
    end
  end

  sequence s_write_strength;
    strength_write_out [*6] ##1 !strength_write_out;
  endsequence

  AST_PIN_HOLD: assert property (@(posedge ck) disable iff (reset_in)
    $rose(term_pin) |-> term_pin [*4]) else $error("pin high too short");
  AST_WR_HOLD: assert property (@(posedge ck) disable iff (reset_in)
    wr_w && term_pin && mr0_q[1:0] == odtc_pkg::BL_FIXED8 |-> term_pin [*6])
    else $error("pin dropped too soon after write");
  AST_LOOP_OFF: assert property (@(posedge ck) disable iff (reset_in)
    mr1_q[0] |=> !term_pin) else $error("pin high with loop off");
  AST_ON_LAT: assert property (@(posedge ck) disable iff (reset_in)
    $rose(term_pin) && live_w |-> ##3 !term_on_out ##1 term_on_out)
    else $error("turn on latency wrong");
  AST_OFF_LAT: assert property (@(posedge ck) disable iff (reset_in)
    $fell(term_pin) && live_w |-> ##3 term_on_out ##1 !term_on_out)
    else $error("turn off latency wrong");
  AST_CNW: assert property (@(posedge ck) disable iff (reset_in)
    wr_w && mr2_q[10:9] != 2'h0 && live_w && mr0_q[1:0] == odtc_pkg::BL_FIXED8
    |-> ##4 s_write_strength) else $error("write strength window wrong");
  AST_SR_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
    self_refresh_out [*2] |-> !term_on_out) else $error("termination in self refresh");
  AST_DRIVE_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
    drive_out [*2] |-> !term_on_out) else $error("termination while driving");
  AST_ASYNC_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
    !sync_mode_out [*2] |-> !term_on_out) else $error("termination outside sync mode");
endmodule

// ### tb/tb.sv
/*
  Self-checking bench joining controller and device over the link.
  Assumes mclk_in at 125 MHz and the default link divider of 160 ns.
*/
`timescale 1ns/10ps
module tb;
  logic        mclk_in;
  logic        reset_in;
  logic        req_valid_in;
  logic [2:0]  req_cmd_in;
  logic [2:0]  req_bank_in;
  logic [15:0] req_addr_in;
  logic        term_req_in;
  logic        cke_in;
  logic        req_ready_out;
  logic        hold_active_out;
  logic        term_on_out;
  logic [2:0]  strength_out;
  logic        strength_write_out;
  logic        drive_out;
  logic        sync_mode_out;
  logic        self_refresh_out;
  int          n_mismatch;
  int          tests_run;
  int          cyc;

  odtc_link_if odtc_link_if_i();
  odtc_controller odtc_controller_i (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .link(odtc_link_if_i), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
    .req_bank_in(req_bank_in), .req_addr_in(req_addr_in), .term_req_in(term_req_in),
    .cke_in(cke_in), .req_ready_out(req_ready_out), .hold_active_out(hold_active_out));
  odtc_device odtc_device_i (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .link(odtc_link_if_i), .term_on_out(term_on_out), .strength_out(strength_out),
    .strength_write_out(strength_write_out), .drive_out(drive_out),
    .sync_mode_out(sync_mode_out), .self_refresh_out(self_refresh_out));
  odtc_monitor odtc_monitor_i (.mclk_in(mclk_in), .reset_in(reset_in), .ck(odtc_link_if_i.ck),
    .cmd(odtc_link_if_i.cmd), .bank(odtc_link_if_i.bank), .addr(odtc_link_if_i.addr),
    .term_pin(odtc_link_if_i.term_pin), .term_on_out(term_on_out),
    .strength_write_out(strength_write_out), .drive_out(drive_out),
    .sync_mode_out(sync_mode_out), .self_refresh_out(self_refresh_out));

  always #4 mclk_in = ~mclk_in;

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    @(negedge mclk_in);
    req_cmd_in   = c;
    req_bank_in  = b;
    req_addr_in  = a;
    req_valid_in = 1'b1;
    while (req_ready_out !== 1'b1) @(negedge mclk_in);
    @(negedge mclk_in);
    req_valid_in = 1'b0;
  endtask

  // Waits link rises, then lets the device synchroniser settle
  task automatic lc(input int n);
    repeat (n) @(posedge odtc_link_if_i.ck);
    repeat (6) @(negedge mclk_in);
  endtask

  task automatic wait_cmd(input logic [2:0] c);
    while (odtc_link_if_i.cmd !== c) @(posedge odtc_link_if_i.ck);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    reset_in = 1'b1;
    req_valid_in = 1'b0;
    req_cmd_in = 3'h0;
    req_bank_in = 3'h0;
    req_addr_in = 16'h0000;
    term_req_in = 1'b0;
    cke_in = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    repeat (3) @(negedge mclk_in);
    reset_in = 1'b0;
    cke_in = 1'b1;
    term_req_in = 1'b1;
    lc(8);
    chk("term_on_disabled", 3'h0, {2'h0, term_on_out});
    term_req_in = 1'b0;
    lc(6);
    send(odtc_pkg::CMD_MRS, 3'h0, 16'h1000);
    send(odtc_pkg::CMD_MRS, 3'h1, 16'h0004);
    send(odtc_pkg::CMD_MRS, 3'h2, 16'h0400);
    lc(3);
    chk("sync_mode", 3'h1, {2'h0, sync_mode_out});
    term_req_in = 1'b1;
    while (odtc_link_if_i.term_pin !== 1'b1) @(posedge odtc_link_if_i.ck);
    @(negedge mclk_in);
    term_req_in = 1'b0;
    lc(2);
    chk("pin_short_hold", 3'h1, {2'h0, odtc_link_if_i.term_pin});
    lc(10);
    chk("pin_released", 3'h0, {2'h0, odtc_link_if_i.term_pin});
    term_req_in = 1'b1;
    lc(8);
    chk("term_on", 3'h1, {2'h0, term_on_out});
    chk("nominal_code", 3'h1, strength_out);
    chk("nominal_sel", 3'h0, {2'h0, strength_write_out});
    send(odtc_pkg::CMD_WRITE, 3'h0, 16'h0000);
    wait_cmd(odtc_pkg::CMD_WRITE);
    lc(4);
    chk("write_sel", 3'h1, {2'h0, strength_write_out});
    chk("write_code", 3'h2, strength_out);
    chk("term_on_in_write", 3'h1, {2'h0, term_on_out});
    lc(5);
    chk("write_sel_late", 3'h1, {2'h0, strength_write_out});
    lc(1);
    chk("nominal_back", 3'h1, strength_out);
    term_req_in = 1'b0;
    lc(8);
    chk("term_off", 3'h0, {2'h0, term_on_out});
    send(odtc_pkg::CMD_WRITE, 3'h0, 16'h0000);
    wait_cmd(odtc_pkg::CMD_WRITE);
    lc(4);
    chk("write_sel_off", 3'h1, {2'h0, strength_write_out});
    chk("term_stays_off", 3'h0, {2'h0, term_on_out});
    lc(8);
    term_req_in = 1'b1;
    lc(8);
    send(odtc_pkg::CMD_READ, 3'h0, 16'h0000);
    wait_cmd(odtc_pkg::CMD_READ);
    lc(6);
    chk("drive", 3'h1, {2'h0, drive_out});
    chk("term_off_read", 3'h0, {2'h0, term_on_out});
    chk("read_block", 3'h1, {2'h0, hold_active_out});
    lc(12);
    chk("term_after_read", 3'h1, {2'h0, term_on_out});
    cke_in = 1'b0;
    send(odtc_pkg::CMD_SRE, 3'h0, 16'h0000);
    lc(4);
    chk("self_refresh", 3'h1, {2'h0, self_refresh_out});
    chk("term_off_sr", 3'h0, {2'h0, term_on_out});
    cke_in = 1'b1;
    lc(10);
    chk("sr_exit_term", 3'h1, {2'h0, term_on_out});
    chk("hold_idle", 3'h0, {2'h0, hold_active_out});
    send(odtc_pkg::CMD_MRS, 3'h1, 16'h0005);
    lc(8);
    chk("loop_off_sync", 3'h0, {2'h0, sync_mode_out});
    chk("loop_off_pin", 3'h0, {2'h0, odtc_link_if_i.term_pin});
    send(odtc_pkg::CMD_MRS, 3'h2, 16'h0000);
    send(odtc_pkg::CMD_WRITE, 3'h0, 16'h0000);
    lc(8);
    chk("dyn_disabled", 3'h0, {2'h0, strength_write_out});
    tally_and_finish();
  end
endmodule
